// File: rtl/hhb_pkg.sv
// Package for the hex half-bridge serial control port.
// Assumes a single 50 MHz system clock domain and a synchronous reset.
package hhb_pkg;
   localparam int WORD_W = 16;
   localparam logic [15:0] CTRL_RESET = 16'he000;
   localparam int BIT_CLEAR   = 0;
   localparam int BIT_SW_LO   = 1;
   localparam int BIT_SW_HI   = 12;
   localparam int BIT_OLCHK_N = 13;
   localparam int BIT_DELAY   = 14;
   localparam int BIT_SOFT_EN = 15;
   localparam int ST_WARN     = 0;
   localparam int ST_SHORT    = 13;
   localparam int ST_ENABLE   = 14;
   localparam int ST_SUPPLY   = 15;
   localparam int SYNC_STAGES = 2;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [15:0] ALL_ONES = 16'hffff;
   typedef enum logic [1:0] {HHB_IDLE, HHB_SHIFT, HHB_APPLY} hhb_state_t;
endpackage

// File: rtl/hhb_sync_if.sv
// Interface bundling the synchronised serial pins and their edges.
// Driven by the pin synchroniser, read by the control core.
interface hhb_sync_if;
   logic selN;
   logic selFall;
   logic selRise;
   logic sckFall;
   logic sckRise;
   logic din;
   logic enPin;
   modport src (output selN, selFall, selRise, sckFall, sckRise, din, enPin);
   modport dst (input selN, selFall, selRise, sckFall, sckRise, din, enPin);
endinterface

// File: rtl/hhb_pin_sync.sv
// Two-flop synchronisers for the serial pins and the enable pin, plus
// edge detection on the synchronised chip select and shift clock.
// Assumes all inputs are asynchronous to clk.
module hhb_pin_sync
   import hhb_pkg::*;
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic csN,
   input  wire logic sck,
   input  wire logic sdi,
   input  wire logic en,
   hhb_sync_if.src   so
);
   logic [3:0] meta_q, meta_d;
   logic [3:0] sync_q, sync_d;
   logic [1:0] prev_q, prev_d;

   always_comb begin
      meta_d = {en, sdi, sck, csN};
      sync_d = meta_q;
      prev_d = sync_q[1:0];
   end

   // Chip select idles high so reset values avoid a false frame start.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= 4'h1;
         sync_q <= 4'h1;
         prev_q <= 2'h1;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   assign so.selN    = sync_q[0];
   assign so.selFall = prev_q[0] & ~sync_q[0];
   assign so.selRise = ~prev_q[0] & sync_q[0];
   assign so.sckFall = prev_q[1] & ~sync_q[1];
   assign so.sckRise = ~prev_q[1] & sync_q[1];
   assign so.din     = sync_q[2];
   assign so.enPin   = sync_q[3];
endmodule

// File: rtl/hhb_serial_ctrl.sv
// Serial control port of a six half-bridge load driver.
// Assumes the host drives chip select, shift clock and data in; the
// analog protection supplies the fault status inputs.
// Functional notes
// - Chip select falling starts a new frame.
// - Control word applied on chip select rising.
// - Input bits sampled on shift clock falling.
// - Data out driven from chip select falling.
// - Data out changes only on clock rising.
// - Data out high impedance while deselected.
// - Status word shifted out LSB first.
// - Clear bit clears supply, short, shutdown flags.
// - Bits one to twelve switch drivers.
// - Bit thirteen low enables open-load checking.
// - Bit fourteen high selects longer short delay.
// - Bit fifteen is software enable.
// - Enable pin low means standby.
// - Fault pin pulled low on heat or overcurrent.
// - Status bits report drivers, short, enable, supply.
// - Shutdown reports all status bits high.
// - Reset control word has bits 15..13 set.
// - Outputs run only when both enables high.
module hhb_serial_ctrl
   import hhb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        chipSelN,
   input  wire logic        shiftClk,
   input  wire logic        serialIn,
   input  wire logic        enablePin,
   input  wire logic [11:0] driverSense,
   input  wire logic        heatWarning,
   input  wire logic        heatShutdown,
   input  wire logic        overCurrent,
   input  wire logic        shortEvent,
   input  wire logic        supplyLow,
   output logic             serialOut,
   output logic             serialOutEn,
   output logic             faultOut,
   output logic             faultOutEn,
   output logic [11:0]      driverOn,
   output logic             openLoadCheckOn,
   output logic             shortDelayLong,
   output logic             deviceEnabled,
   output logic             statusClear
);
   ////////////////////////////////////////////////////////////////////////
   hhb_sync_if pins ();

   hhb_pin_sync u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .csN     (chipSelN),
      .sck     (shiftClk),
      .sdi     (serialIn),
      .en      (enablePin),
      .so      (pins)
   );

   ////////////////////////////////////////////////////////////////////////
   // Frame state and shift registers.
   hhb_state_t  state_q, state_d;
   logic [15:0] inSr_q, inSr_d;
   logic [15:0] outSr_q, outSr_d;
   logic [15:0] ctrl_q, ctrl_d;
   logic        sdo_q, sdo_d;
   logic        sdoEn_q, sdoEn_d;
   logic        clr_q, clr_d;
   logic [3:0]  bitCnt_q, bitCnt_d;

   // Sticky supply, short and shutdown flags set by the protection, cleared by the clear bit; then the registered outputs.
   logic        supFail_q, supFail_d;
   logic        shortFound_q, shortFound_d;
   logic        shut_q, shut_d;
   logic        fault_q, fault_d;
   logic [11:0] drv_q, drv_d;
   logic        olOn_q, olOn_d;
   logic        dly_q, dly_d;
   logic        en_q, en_d;

   logic [15:0] statusWord;
   logic        bothEn;

   assign bothEn = pins.enPin & ctrl_q[BIT_SOFT_EN];

   // Status word as loaded at the start of each frame.
   always_comb begin
      statusWord = 16'h0000;
      statusWord[ST_WARN] = heatWarning;
      statusWord[BIT_SW_HI:BIT_SW_LO] = driverSense;
      statusWord[ST_SHORT]  = shortFound_q;
      statusWord[ST_ENABLE] = bothEn;
      statusWord[ST_SUPPLY] = supFail_q;
      if (shut_q) begin
         statusWord = ALL_ONES;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d  = state_q;
      inSr_d   = inSr_q;
      outSr_d  = outSr_q;
      ctrl_d   = ctrl_q;
      sdo_d    = sdo_q;
      sdoEn_d  = sdoEn_q;
      clr_d    = 1'b0;
      bitCnt_d = bitCnt_q;
      case (state_q)
         HHB_IDLE: begin
            sdoEn_d = 1'b0;
            if (pins.selFall) begin
               state_d  = HHB_SHIFT;
               outSr_d  = statusWord;
               sdo_d    = statusWord[ST_WARN];
               sdoEn_d  = 1'b1;
               bitCnt_d = CNT_ZERO;
            end
         end
         HHB_SHIFT: begin
            if (pins.selRise) begin
               state_d = HHB_APPLY;
               sdoEn_d = 1'b0;
            end else begin
               if (pins.sckFall) begin
                  // Input arrives LSB first, so shift toward bit zero.
                  inSr_d = {pins.din, inSr_q[15:1]};
                  bitCnt_d = 4'(bitCnt_q + 4'h1);
               end
               if (pins.sckRise) begin
                  // First rising edge presents bit one; bit zero shows
                  // from the frame start.
                  outSr_d = {1'b0, outSr_q[15:1]};
                  sdo_d   = outSr_q[1];
               end
            end
         end
         HHB_APPLY: begin
            // A partial frame leaves data misaligned, but a full
            // sixteen-clock frame is expected from the host.
            ctrl_d  = inSr_q;
            clr_d   = inSr_q[BIT_CLEAR];
            state_d = HHB_IDLE;
         end
         default: begin
            state_d = HHB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q  <= HHB_IDLE;
         inSr_q   <= 16'h0000;
         outSr_q  <= 16'h0000;
         ctrl_q   <= CTRL_RESET;
         sdo_q    <= 1'b0;
         sdoEn_q  <= 1'b0;
         clr_q    <= 1'b0;
         bitCnt_q <= CNT_ZERO;
      end else begin
         state_q  <= state_d;
         inSr_q   <= inSr_d;
         outSr_q  <= outSr_d;
         ctrl_q   <= ctrl_d;
         sdo_q    <= sdo_d;
         sdoEn_q  <= sdoEn_d;
         clr_q    <= clr_d;
         bitCnt_q <= bitCnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags: a protection event in the clear cycle wins over the clear.
   always_comb begin
      supFail_d    = supFail_q;
      shortFound_d = shortFound_q;
      shut_d       = shut_q;
      if (clr_q) begin
         supFail_d    = 1'b0;
         shortFound_d = 1'b0;
         shut_d       = 1'b0;
      end
      if (supplyLow) begin
         supFail_d = 1'b1;
      end
      if (shortEvent) begin
         shortFound_d = 1'b1;
      end
      if (heatShutdown) begin
         shut_d = 1'b1;
      end
      fault_d = heatShutdown | overCurrent | shut_d;
      drv_d   = bothEn ? ctrl_q[BIT_SW_HI:BIT_SW_LO] : 12'h000;
      olOn_d  = ~ctrl_q[BIT_OLCHK_N];
      dly_d   = ctrl_q[BIT_DELAY];
      en_d    = bothEn;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         supFail_q    <= 1'b0;
         shortFound_q <= 1'b0;
         shut_q       <= 1'b0;
         fault_q      <= 1'b0;
         drv_q        <= 12'h000;
         olOn_q       <= 1'b0;
         dly_q        <= 1'b1;
         en_q         <= 1'b0;
      end else begin
         supFail_q    <= supFail_d;
         shortFound_q <= shortFound_d;
         shut_q       <= shut_d;
         fault_q      <= fault_d;
         drv_q        <= drv_d;
         olOn_q       <= olOn_d;
         dly_q        <= dly_d;
         en_q         <= en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign serialOut       = sdo_q;
   assign serialOutEn     = sdoEn_q;
   assign faultOut        = 1'b0;
   assign faultOutEn      = fault_q;
   assign driverOn        = drv_q;
   assign openLoadCheckOn = olOn_q;
   assign shortDelayLong  = dly_q;
   assign deviceEnabled   = en_q;
   assign statusClear     = clr_q;
endmodule

// File: sim/hhb_serial_ctrl_props.sv
// Checker for the serial control port, bound to its top module.
// Sees the top ports only; one clock domain.
module hhb_serial_ctrl_props (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        chipSelN,
   input wire logic        shiftClk,
   input wire logic        enablePin,
   input wire logic        overCurrent,
   input wire logic        serialOut,
   input wire logic        serialOutEn,
   input wire logic        faultOutEn,
   input wire logic [11:0] driverOn,
   input wire logic        openLoadCheckOn,
   input wire logic        shortDelayLong,
   input wire logic        deviceEnabled,
   input wire logic        statusClear
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_sel_low;
      (!chipSelN)[*8];
   endsequence
   sequence s_desel;
      chipSelN[*6];
   endsequence
   property p_oe_off;
      s_desel |-> !serialOutEn;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("data out driven while deselected");
   property p_oe_on;
      $fell(chipSelN) |-> ##[1:6] serialOutEn;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("data out not enabled after select");
   property p_sdo;
      serialOutEn && $past(serialOutEn) && $changed(serialOut)
         |-> $past(shiftClk, 3) || $past(shiftClk, 4);
   endproperty
   a_sdo: assert property (p_sdo)
      else $error("data out changed away from a rising clock");
   property p_clr_at;
      statusClear |-> chipSelN && $past(chipSelN, 3);
   endproperty
   a_clr_at: assert property (p_clr_at)
      else $error("clear pulse not after select release");
   property p_clr_one;
      statusClear |=> !statusClear;
   endproperty
   a_clr_one: assert property (p_clr_one)
      else $error("clear pulse longer than one cycle");
   property p_hold;
      s_sel_low |-> $stable(shortDelayLong) && $stable(openLoadCheckOn);
   endproperty
   a_hold: assert property (p_hold)
      else $error("settings changed inside a frame");
   property p_gate;
      !deviceEnabled && !$past(deviceEnabled) |-> driverOn == 12'h000;
   endproperty
   a_gate: assert property (p_gate)
      else $error("driver on while disabled");
   property p_en_pin;
      (!enablePin)[*6] |-> !deviceEnabled;
   endproperty
   a_en_pin: assert property (p_en_pin)
      else $error("enabled with enable pin low");
   property p_fault;
      overCurrent[*3] |-> faultOutEn;
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault not pulled on overcurrent");
endmodule

// File: sim/hhb_host_model.sv
// Host side of the serial link: one 16-bit frame per call.
// Assumes the caller waits for the task; data in idles low (pull-down).
module hhb_host_model (
   input  wire logic clk,
   output logic      csN,
   output logic      sck,
   output logic      sdi,
   input  wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
   end
   // Data moves two cycles after the falling clock so the hold is safe.
   task automatic xfer(input logic [15:0] w, output logic [15:0] st);
      @(posedge clk) csN <= 1'b0;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 16; i++) begin
         repeat (2) @(posedge clk);
         sdi <= w[i];
         repeat (2) @(posedge clk);
         st[i] = sdo;
         sck <= 1'b1;
         repeat (4) @(posedge clk);
         sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      sdi <= 1'b0;
      csN <= 1'b1;
      repeat (14) @(posedge clk);
   endtask
endmodule

// File: sim/testbench.sv
// Top bench: frames through the host model, checks status and outputs.
// Assumes the checker is bound below and the design resets to idle.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import hhb_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, enablePin = 1'b1;
   logic heatWarning = 1'b0, heatShutdown = 1'b0, overCurrent = 1'b0;
   logic shortEvent = 1'b0, supplyLow = 1'b0;
   logic [11:0] driverSense = 12'ha5c;
   logic chipSelN, shiftClk, serialIn, serialOut, serialOutEn;
   logic faultOut, faultOutEn, openLoadCheckOn, shortDelayLong;
   logic deviceEnabled, statusClear;
   logic [11:0] driverOn;
   int miscompares = 0, n_tests = 0, cycles = 0;
   wire sdoLine = serialOutEn ? serialOut : 1'bz;
   wire [15:0] outs = {deviceEnabled, shortDelayLong, openLoadCheckOn,
                       driverOn, 1'b0};
   hhb_serial_ctrl i_dut (.clk, .sys_rst, .chipSelN, .shiftClk,
      .serialIn, .enablePin, .driverSense, .heatWarning, .heatShutdown,
      .overCurrent, .shortEvent, .supplyLow, .serialOut, .serialOutEn,
      .faultOut, .faultOutEn, .driverOn, .openLoadCheckOn,
      .shortDelayLong, .deviceEnabled, .statusClear);
   hhb_host_model i_host (.clk, .csN(chipSelN), .sck(shiftClk),
      .sdi(serialIn), .sdo(sdoLine));
   always #10 clk = ~clk;
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xf(input logic [15:0] w, input logic [15:0] exp);
      logic [15:0] st;
      i_host.xfer(w, st);
      chk(st, exp);
   endtask
   // The ceiling is about eighteen times the expected run of about 1100 cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      heatWarning <= 1'b1;
      repeat (8) @(posedge clk);
      chk(outs, 16'hc000);
      xf(16'h8aab, 16'h54b9);
      chk(outs, 16'haaaa);
      heatWarning <= 1'b0;
      xf(16'h7ffe, 16'h54b8);
      chk(outs, 16'h4000);
      xf(16'hfffe, 16'h14b8);
      chk(outs, 16'hdffe);
      enablePin <= 1'b0;
      repeat (8) @(posedge clk);
      chk(outs, 16'h4000);
      enablePin <= 1'b1;
      shortEvent <= 1'b1;
      supplyLow <= 1'b1;
      @(posedge clk);
      shortEvent <= 1'b0;
      supplyLow <= 1'b0;
      xf(16'h8001, 16'hf4b8);
      xf(16'h8000, 16'h54b8);
      heatShutdown <= 1'b1;
      repeat (2) @(posedge clk);
      heatShutdown <= 1'b0;
      repeat (4) @(posedge clk);
      chk({15'h0000, faultOutEn}, 16'h0001);
      xf(16'h8001, 16'hffff);
      chk({15'h0000, faultOutEn}, 16'h0000);
      xf(16'h8000, 16'h54b8);
      overCurrent <= 1'b1;
      repeat (5) @(posedge clk);
      chk({15'h0000, faultOutEn}, 16'h0001);
      overCurrent <= 1'b0;
      repeat (5) @(posedge clk);
      chk({15'h0000, faultOutEn}, 16'h0000);
      chk({15'h0000, faultOut}, 16'h0000);
      tally_and_finish();
   end
endmodule
bind hhb_serial_ctrl hhb_serial_ctrl_props i_props (.clk, .sys_rst,
   .chipSelN, .shiftClk, .enablePin, .overCurrent, .serialOut,
   .serialOutEn, .faultOutEn, .driverOn, .openLoadCheckOn,
   .shortDelayLong, .deviceEnabled, .statusClear);
